// *** design/tmfh_defs.svh ***
// Operation
// - A good block read answer is 07h, 8-byte id, two flag bytes, the count echo and 16 bytes a block.
// - A block read answer that is not normal end drops count and data.
// - APDU read answers give 1 to 251 bytes on normal end, then SW1 SW2.
// - A block write is refused unless the service count lies in 01h to 0Bh.
// - Service codes are ignored, but differing codes are refused.
// - The write block count is 01h-0Ch for 1 to 8 services, else 01h-0Bh.
// - An APDU write needs class 00h and D6h; its P1 and P2 are the address.
// - Hosts poll with 28h and get status, address, length and write data.
// - Address goes high byte first; address and length count bytes.
// - A block write answer is 09h, 8-byte id and two flag bytes, no data.
// - An APDU write answer is only the two status word bytes.
`ifndef TMFH_DEFS_SVH
`define TMFH_DEFS_SVH
`define TMFH_CMD_RD 8'h06
`define TMFH_CMD_WR 8'h08
`define TMFH_RSP_RD 8'h07
`define TMFH_RSP_WR 8'h09
`define TMFH_CLA 8'h00
`define TMFH_INS_RD 8'hB0
`define TMFH_INS_WR 8'hD6
`define TMFH_POLL 8'h28
`define TMFH_ANS_OK 8'hF8
`define TMFH_ANS_ERR 8'hE8
`define TMFH_K_MAX_RD 8'h0F
`define TMFH_K_MAX_WR 8'h0B
`define TMFH_K_SPLIT 8'h08
`define TMFH_M_MAX_RD 8'h0F
`define TMFH_M_MAX_LO 8'h0C
`define TMFH_M_MAX_HI 8'h0B
`define TMFH_LE_MAX 8'hFB
`define TMFH_LC_MAX 8'hF8
`define TMFH_POS_K 9'h009
`define TMFH_POS_SVC 9'h00A
`define TMFH_POS_SF1 9'h009
`define TMFH_POS_M 9'h00B
`define TMFH_POS_BD 9'h00C
`define TMFH_POS_APDU_DATA 9'h005
`define TMFH_POS_QDATA 9'h004
`endif

// *** design/tmfh_pkg.sv ***
`default_nettype none
package tmfh_pkg;
    // Sequencer states, one-hot.
    typedef enum logic [6:0] {
        TMFH_RX = 7'h01,
        TMFH_POLL = 7'h02,
        TMFH_QRSP = 7'h04,
        TMFH_ANS = 7'h08,
        TMFH_RDAT = 7'h10,
        TMFH_ACK = 7'h20,
        TMFH_RFRSP = 7'h40
    } tmfh_state_t;
endpackage : tmfh_pkg
`default_nettype wire

// *** design/tmfh_top.sv ***
`include "tmfh_defs.svh"
`default_nettype none
module tmfh_top #(
    parameter int DEPTH = 512,
    parameter logic [7:0] Q_STATUS = 8'h00,
    parameter logic [7:0] ACK_STATUS = 8'h00,
    parameter logic [7:0] FLAG1_ERR = 8'hFF,
    parameter logic [7:0] FLAG2_ERR = 8'h01,
    parameter logic [15:0] SW_OK = 16'h9000,
    parameter logic [15:0] SW_ERR = 16'h6A80
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Radio side request bytes.
    input wire logic i_rf_valid,
    input wire logic [7:0] i_rf_data,
    input wire logic i_rf_last,
    input wire logic i_rf_apdu,
    // Radio side answer bytes.
    output logic o_rf_valid,
    output logic [7:0] o_rf_data,
    output logic o_rf_last,
    // Host side command bytes.
    input wire logic i_host_valid,
    input wire logic [7:0] i_host_data,
    // Host side answer bytes.
    output logic o_host_valid,
    output logic [7:0] o_host_data,
    output logic o_host_last,
    // Sequencer status.
    output logic o_busy
);
    localparam int AW = 9;

    // ****************************************
    // Storage and parameter checks
    // ****************************************
    // The index logic is sized for exactly one full 512-byte buffer.
    if (DEPTH != 2 ** AW) begin : g_depth_check
        $error("DEPTH must be 512");
    end

    logic [7:0] rx_mem [DEPTH];
    logic [7:0] rd_mem [256];
    tmfh_pkg::tmfh_state_t st_q;
    logic [AW-1:0] rx_cnt_q;
    logic rx_done_q;
    logic apdu_q;
    logic wr_q;
    logic err_q;
    logic ans_ok_q;
    logic [15:0] addr_q;
    logic [7:0] len_q;
    logic [7:0] m_q;
    logic [AW-1:0] dstart_q;
    logic [AW-1:0] idx_q;

    // The frame buffer is pure data, so it carries no reset.
    always_ff @(posedge i_clk) begin
        if (st_q == tmfh_pkg::TMFH_RX && i_rf_valid) begin
            rx_mem[rx_cnt_q] <= i_rf_data;
        end
    end

    // Read data from the host is kept apart so the card id survives.
    always_ff @(posedge i_clk) begin
        if (st_q == tmfh_pkg::TMFH_RDAT && i_host_valid) begin
            rd_mem[idx_q[7:0]] <= i_host_data;
        end
    end

    // ****************************************
    // Request decode
    // ****************************************
    logic dec_err;
    logic dec_wr;
    logic [15:0] dec_addr;
    logic [7:0] dec_len;
    logic [AW-1:0] dec_dstart;
    logic [7:0] k;
    logic [7:0] m;
    logic [AW-1:0] mpos;
    logic [AW-1:0] need;

    // Fields are decoded once the whole frame is stored.
    always_comb begin
        k = rx_mem[`TMFH_POS_K];
        mpos = `TMFH_POS_SVC + {k, 1'b0};
        m = rx_mem[mpos];
        need = mpos + 9'h001 + {m, 1'b0};
        dec_err = 1'b0;
        dec_wr = 1'b0;
        dec_addr = 16'h0000;
        dec_len = 8'h00;
        dec_dstart = `TMFH_POS_APDU_DATA;
        if (apdu_q) begin
            dec_addr = {rx_mem[2], rx_mem[3]};
            dec_len = rx_mem[4];
            dec_err = rx_mem[0] != `TMFH_CLA;
            dec_wr = rx_mem[1] == `TMFH_INS_WR;
            if (rx_mem[1] != `TMFH_INS_WR && rx_mem[1] != `TMFH_INS_RD) begin
                dec_err = 1'b1;
            end
            if (dec_len == 8'h00) begin
                dec_err = 1'b1;
            end
            if (!dec_wr && dec_len > `TMFH_LE_MAX) begin
                dec_err = 1'b1;
            end
            if (dec_wr && (dec_len > `TMFH_LC_MAX
                    || rx_cnt_q != 9'h005 + {1'b0, dec_len})) begin
                dec_err = 1'b1;
            end
        end else begin
            dec_wr = rx_mem[0] == `TMFH_CMD_WR;
            if (rx_mem[0] != `TMFH_CMD_WR && rx_mem[0] != `TMFH_CMD_RD) begin
                dec_err = 1'b1;
            end
            // Block number of the first list element, sixteen bytes each.
            dec_addr = {4'h0, rx_mem[mpos + 9'h002], 4'h0};
            dec_len = {m[3:0], 4'h0};
            dec_dstart = rx_cnt_q - {1'b0, m[3:0], 4'h0};
            if (k == 8'h00 || m == 8'h00) begin
                dec_err = 1'b1;
            end
            if (dec_wr) begin
                if (k > `TMFH_K_MAX_WR) begin
                    dec_err = 1'b1;
                end
                if (k <= `TMFH_K_SPLIT && m > `TMFH_M_MAX_LO) begin
                    dec_err = 1'b1;
                end
                if (k > `TMFH_K_SPLIT && m > `TMFH_M_MAX_HI) begin
                    dec_err = 1'b1;
                end
                if (rx_cnt_q < need + {1'b0, m[3:0], 4'h0}) begin
                    dec_err = 1'b1;
                end
            end else if (k > `TMFH_K_MAX_RD || m > `TMFH_M_MAX_RD) begin
                dec_err = 1'b1;
            end
            // Service codes only have to agree with the first one.
            for (int i = 1; i < 15; i++) begin
                if (8'(i) < k) begin
                    if (rx_mem[`TMFH_POS_SVC + 9'(2 * i)] != rx_mem[10]
                            || rx_mem[`TMFH_POS_SVC + 9'(2 * i + 1)]
                            != rx_mem[11]) begin
                        dec_err = 1'b1;
                    end
                end
            end
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    logic host_end;
    logic rf_end;
    logic [AW-1:0] rf_last_idx;

    assign host_end = (st_q == tmfh_pkg::TMFH_ACK)
        || (idx_q == 9'h003 + (wr_q ? {1'b0, len_q} : 9'h000));
    assign rf_end = idx_q == rf_last_idx;

    // Last radio byte index, depending on framing and outcome.
    always_comb begin
        if (apdu_q) begin
            rf_last_idx = (!wr_q && !err_q && ans_ok_q)
                ? {1'b0, len_q} + 9'h001 : 9'h001;
        end else if (!wr_q && !err_q && ans_ok_q) begin
            rf_last_idx = `TMFH_POS_M + {1'b0, len_q};
        end else begin
            rf_last_idx = 9'h00A;
        end
    end

    // Frame collection; the count stops at 1FFh, so bytes past the buffer overwrite its last byte.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_cnt_q <= 9'h000;
            rx_done_q <= 1'b0;
            apdu_q <= 1'b0;
        end else if (st_q != tmfh_pkg::TMFH_RX) begin
            rx_cnt_q <= 9'h000;
            rx_done_q <= 1'b0;
        end else begin
            rx_done_q <= i_rf_valid && i_rf_last;
            if (rx_done_q) begin
                rx_cnt_q <= 9'h000;
            end else if (i_rf_valid && rx_cnt_q != 9'h1FF) begin
                rx_cnt_q <= rx_cnt_q + 9'h001;
            end
            if (i_rf_valid && i_rf_last) begin
                apdu_q <= i_rf_apdu;
            end
        end
    end

    // Main flow; radio frames during a transaction are ignored.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= tmfh_pkg::TMFH_RX;
            wr_q <= 1'b0;
            err_q <= 1'b0;
            ans_ok_q <= 1'b0;
            addr_q <= 16'h0000;
            len_q <= 8'h00;
            m_q <= 8'h00;
            dstart_q <= 9'h000;
            idx_q <= 9'h000;
        end else begin
            case (st_q)
                tmfh_pkg::TMFH_RX: begin
                    idx_q <= 9'h000;
                    if (rx_done_q) begin
                        wr_q <= dec_wr;
                        err_q <= dec_err;
                        ans_ok_q <= 1'b0;
                        addr_q <= dec_addr;
                        len_q <= dec_len;
                        m_q <= m;
                        dstart_q <= dec_dstart;
                        st_q <= dec_err ? tmfh_pkg::TMFH_RFRSP
                            : tmfh_pkg::TMFH_POLL;
                    end
                end
                tmfh_pkg::TMFH_POLL: begin
                    if (i_host_valid && i_host_data == `TMFH_POLL) begin
                        st_q <= tmfh_pkg::TMFH_QRSP;
                    end
                end
                tmfh_pkg::TMFH_QRSP: begin
                    idx_q <= host_end ? 9'h000 : idx_q + 9'h001;
                    if (host_end) begin
                        st_q <= tmfh_pkg::TMFH_ANS;
                    end
                end
                tmfh_pkg::TMFH_ANS: begin
                    if (i_host_valid && (i_host_data == `TMFH_ANS_OK
                            || i_host_data == `TMFH_ANS_ERR)) begin
                        ans_ok_q <= i_host_data == `TMFH_ANS_OK;
                        st_q <= (!wr_q && i_host_data == `TMFH_ANS_OK)
                            ? tmfh_pkg::TMFH_RDAT : tmfh_pkg::TMFH_ACK;
                    end
                end
                tmfh_pkg::TMFH_RDAT: begin
                    if (i_host_valid) begin
                        idx_q <= idx_q + 9'h001;
                        if (idx_q == {1'b0, len_q} - 9'h001) begin
                            idx_q <= 9'h000;
                            st_q <= tmfh_pkg::TMFH_ACK;
                        end
                    end
                end
                tmfh_pkg::TMFH_ACK: begin
                    st_q <= tmfh_pkg::TMFH_RFRSP;
                end
                tmfh_pkg::TMFH_RFRSP: begin
                    idx_q <= rf_end ? 9'h000 : idx_q + 9'h001;
                    if (rf_end) begin
                        st_q <= tmfh_pkg::TMFH_RX;
                    end
                end
                default: begin
                    st_q <= tmfh_pkg::TMFH_RX;
                end
            endcase
        end
    end

    // ****************************************
    // Output byte streams
    // ****************************************
    logic [7:0] host_byte;
    logic [7:0] rf_byte;
    logic good;
    logic [15:0] sw;

    assign good = !err_q && ans_ok_q;
    assign sw = good ? SW_OK : SW_ERR;

    // Poll answer: status, address high first, length, then write data.
    always_comb begin
        case (idx_q)
            9'h000: host_byte = Q_STATUS;
            9'h001: host_byte = addr_q[15:8];
            9'h002: host_byte = addr_q[7:0];
            9'h003: host_byte = len_q;
            default: host_byte = rx_mem[dstart_q + idx_q - `TMFH_POS_QDATA];
        endcase
        if (st_q == tmfh_pkg::TMFH_ACK) begin
            host_byte = ACK_STATUS;
        end
    end

    // Radio answer bytes for both framings.
    always_comb begin
        if (apdu_q) begin
            if (idx_q == rf_last_idx) begin
                rf_byte = sw[7:0];
            end else if (idx_q == rf_last_idx - 9'h001) begin
                rf_byte = sw[15:8];
            end else begin
                rf_byte = rd_mem[idx_q[7:0]];
            end
        end else if (idx_q == 9'h000) begin
            rf_byte = wr_q ? `TMFH_RSP_WR : `TMFH_RSP_RD;
        end else if (idx_q < `TMFH_POS_SF1) begin
            rf_byte = rx_mem[idx_q];
        end else if (idx_q == `TMFH_POS_SF1) begin
            rf_byte = good ? 8'h00 : FLAG1_ERR;
        end else if (idx_q == 9'h00A) begin
            rf_byte = good ? 8'h00 : FLAG2_ERR;
        end else if (idx_q == `TMFH_POS_M) begin
            rf_byte = m_q;
        end else begin
            rf_byte = rd_mem[8'(idx_q - `TMFH_POS_BD)];
        end
    end

    // Registered outputs toward the host.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_host_valid <= 1'b0;
            o_host_data <= 8'h00;
            o_host_last <= 1'b0;
        end else begin
            o_host_valid <= st_q == tmfh_pkg::TMFH_QRSP
                || st_q == tmfh_pkg::TMFH_ACK;
            o_host_data <= host_byte;
            o_host_last <= (st_q == tmfh_pkg::TMFH_QRSP && host_end)
                || st_q == tmfh_pkg::TMFH_ACK;
        end
    end

    // Registered outputs toward the radio.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rf_valid <= 1'b0;
            o_rf_data <= 8'h00;
            o_rf_last <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            o_rf_valid <= st_q == tmfh_pkg::TMFH_RFRSP;
            o_rf_data <= rf_byte;
            o_rf_last <= st_q == tmfh_pkg::TMFH_RFRSP && rf_end;
            o_busy <= st_q != tmfh_pkg::TMFH_RX;
        end
    end
endmodule : tmfh_top
`default_nettype wire

// *** verif/tmfh_properties.sv ***
`default_nettype none
// ****************************************
// Protocol checker for the frame handler.
// ****************************************
module tmfh_properties #(
    parameter logic [7:0] Q_STATUS = 8'h00,
    parameter logic [7:0] ACK_STATUS = 8'h00
) (
    // Clock, reset and radio side.
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_rf_valid,
    input wire logic [7:0] i_rf_data,
    input wire logic i_rf_last,
    input wire logic i_rf_apdu,
    input wire logic o_rf_valid,
    input wire logic [7:0] o_rf_data,
    input wire logic o_rf_last,
    // Host side and status.
    input wire logic i_host_valid,
    input wire logic [7:0] i_host_data,
    input wire logic o_host_valid,
    input wire logic [7:0] o_host_data,
    input wire logic o_host_last,
    input wire logic o_busy
);
    logic q_seen_q, ans_q, ap_q, ans_ev;
    logic [1:0] ix_q;
    logic [7:0] b0_q, b1_q;
    logic [8:0] rc_q;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // A host answer only counts once the host_poll_request answer has begun.
    assign ans_ev = o_busy && q_seen_q && !ans_q && i_host_valid &&
        (i_host_data == 8'hF8 || i_host_data == 8'hE8);
    // Host phase of the running transaction, cleared when idle.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q_seen_q <= 1'b0;
            ans_q <= 1'b0;
        end else if (!o_busy) begin
            q_seen_q <= 1'b0;
            ans_q <= 1'b0;
        end else begin
            q_seen_q <= q_seen_q || o_host_valid;
            ans_q <= ans_q || ans_ev;
        end
    end
    // First two request bytes and framing; busy bytes are dropped.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ix_q <= 2'h0;
            b0_q <= 8'h00;
            b1_q <= 8'h00;
            ap_q <= 1'b0;
        end else if (i_rf_valid && !o_busy) begin
            ix_q <= i_rf_last ? 2'h0 : (ix_q == 2'h2 ? ix_q : ix_q + 2'h1);
            if (ix_q == 2'h0) begin
                b0_q <= i_rf_data;
            end
            if (ix_q == 2'h1) begin
                b1_q <= i_rf_data;
            end
            if (i_rf_last) begin
                ap_q <= i_rf_apdu;
            end
        end
    end
    // Byte index within the radio answer.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rc_q <= 9'h000;
        end else if (o_rf_valid) begin
            rc_q <= o_rf_last ? 9'h000 : rc_q + 9'h001;
        end
    end
    property p_poll;
        o_busy && !q_seen_q && i_host_valid && i_host_data == 8'h28 |->
            ##2 o_host_valid && o_host_data == Q_STATUS;
    endproperty
    a_poll: assert property (p_poll)
        else $error("host_poll_request answer late or wrong status");
    property p_err_ack;
        ans_ev && i_host_data == 8'hE8 |->
            ##2 o_host_valid && o_host_last && o_host_data == ACK_STATUS;
    endproperty
    a_err_ack: assert property (p_err_ack)
        else $error("error answer not acknowledged");
    property p_rf_wait;
        o_rf_valid && q_seen_q |-> ans_q;
    endproperty
    a_rf_wait: assert property (p_rf_wait)
        else $error("radio answer before host answer");
    property p_rf_after;
        o_host_valid && o_host_last && ans_q |-> ##[1:3] o_rf_valid;
    endproperty
    a_rf_after: assert property (p_rf_after)
        else $error("radio answer missing after host answer");
    property p_rd_code;
        o_rf_valid && rc_q == 9'h000 && !ap_q && b0_q == 8'h06 |->
            o_rf_data == 8'h07;
    endproperty
    a_rd_code: assert property (p_rd_code)
        else $error("block read answer code wrong");
    property p_wr_code;
        o_rf_valid && rc_q == 9'h000 && !ap_q && b0_q == 8'h08 |->
            o_rf_data == 8'h09;
    endproperty
    a_wr_code: assert property (p_wr_code)
        else $error("block write answer code wrong");
    property p_wr_len;
        o_rf_last && !ap_q && b0_q == 8'h08 |-> rc_q == 9'h00A;
    endproperty
    a_wr_len: assert property (p_wr_len)
        else $error("block write answer length wrong");
    property p_apdu_wr;
        o_rf_last && ap_q && b1_q == 8'hD6 |-> rc_q == 9'h001;
    endproperty
    a_apdu_wr: assert property (p_apdu_wr)
        else $error("APDU write answer length wrong");
    c_wr: cover property (o_rf_last && !ap_q && b0_q == 8'h08);
    c_apdu: cover property (o_rf_last && ap_q && b1_q == 8'hD6);
    c_err: cover property (ans_ev && i_host_data == 8'hE8);
endmodule : tmfh_properties
bind tmfh_top tmfh_properties #(.Q_STATUS(Q_STATUS),
    .ACK_STATUS(ACK_STATUS)) u_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_rf_valid(i_rf_valid), .i_rf_data(i_rf_data), .i_rf_last(i_rf_last),
    .i_rf_apdu(i_rf_apdu), .o_rf_valid(o_rf_valid), .o_rf_data(o_rf_data),
    .o_rf_last(o_rf_last), .i_host_valid(i_host_valid),
    .i_host_data(i_host_data), .o_host_valid(o_host_valid),
    .o_host_data(o_host_data), .o_host_last(o_host_last), .o_busy(o_busy));
`default_nettype wire

// *** verif/tmfh_host_model.sv ***
`default_nettype none
// *************************************
// Behavioural serial host controller.
// *************************************
module tmfh_host_model (
    // Clock, reset and scenario controls.
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_go,
    input wire logic i_err,
    input wire logic i_rd,
    input wire logic i_slow,
    // Host port of the handler.
    input wire logic i_busy,
    input wire logic i_hv,
    input wire logic [7:0] i_hd,
    output logic o_valid,
    output logic [7:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    int n, w, len;
    // Poll once busy, read the host_poll_request answer, then answer; an idle line
    // shows the inverse of the last byte so stale data cannot match.
    initial begin
        o_valid = 1'b0;
        o_data = 8'hA5;
        forever begin
            @(negedge i_clk);
            if (i_rst_n && i_busy && i_go) begin
                repeat (i_slow ? 6 : 1) @(negedge i_clk);
                o_valid = 1'b1;
                o_data = 8'h28;
                @(negedge i_clk);
                o_valid = 1'b0;
                o_data = ~o_data;
                n = 0;
                w = 0;
                len = 0;
                while (w < 40 && (n == 0 || i_hv)) begin
                    if (i_hv && n == 3) len = i_hd;
                    n += i_hv;
                    w += (n == 0);
                    @(negedge i_clk);
                end
                if (n > 0) begin
                    repeat (i_slow ? 4 : 0) @(negedge i_clk);
                    o_valid = 1'b1;
                    o_data = i_err ? 8'hE8 : 8'hF8;
                    @(negedge i_clk);
                    for (int i = 0; i < len && i_rd && !i_err; i++) begin
                        o_data = 8'h40 + i[7:0];
                        @(negedge i_clk);
                    end
                    o_valid = 1'b0;
                    o_data = ~o_data;
                end
                wait (!i_busy || !i_rst_n);
            end
        end
    end
endmodule : tmfh_host_model
`default_nettype wire

// *** verif/tb_tunnel_mode_frame_handler.sv ***
`default_nettype none
// ****************************
// Frame handler testbench.
// ****************************
module tb_tunnel_mode_frame_handler;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] QS = 8'h3C;
    localparam logic [7:0] AS = 8'h5A;
    logic clk, rst_n, rf_v, rf_l, rf_ap, hv, go, err, rd, slow;
    logic o_rv, o_rl, o_hv, o_hl, busy;
    logic [7:0] rf_d, hd, o_rd, o_hd;
    logic [7:0] fr[$], ex[$], hx[$], rs[$], hq[$];
    int bad_count, samples_checked;
    int rf_lst, hs_lst;
    tmfh_top #(.Q_STATUS(QS), .ACK_STATUS(AS)) dut_u (.i_clk(clk),
        .i_rst_n(rst_n), .i_rf_valid(rf_v), .i_rf_data(rf_d),
        .i_rf_last(rf_l), .i_rf_apdu(rf_ap), .o_rf_valid(o_rv),
        .o_rf_data(o_rd), .o_rf_last(o_rl), .i_host_valid(hv),
        .i_host_data(hd), .o_host_valid(o_hv), .o_host_data(o_hd),
        .o_host_last(o_hl), .o_busy(busy));
    tmfh_host_model host_u (.i_clk(clk), .i_rst_n(rst_n), .i_go(go),
        .i_err(err), .i_rd(rd), .i_slow(slow), .i_busy(busy), .i_hv(o_hv),
        .i_hd(o_hd), .o_valid(hv), .o_data(hd));
    // Record every byte the handler sends on either side.
    always @(posedge clk) begin
        if (o_rv && o_rl) rf_lst = rs.size();
        if (o_hv && o_hl) hs_lst = hq.size();
        if (o_rv) rs.push_back(o_rd);
        if (o_hv) hq.push_back(o_hd);
    end
    task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task final_report;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    // Send the frame, wait for the whole answer, compare the radio side and, when g is set, the host side.
    task run(input bit g, input bit e, input bit r, input bit s);
        int w;
        go = g;
        err = e;
        rd = r;
        slow = s;
        rs.delete();
        hq.delete();
        rf_lst = -1;
        hs_lst = -1;
        foreach (fr[i]) begin
            rf_v = 1'b1;
            rf_d = fr[i];
            rf_l = (i == fr.size() - 1);
            @(negedge clk);
        end
        rf_v = 1'b0;
        rf_l = 1'b0;
        rf_d = ~rf_d;
        w = 0;
        while (w < 3000 && !(rs.size() > 0 && !o_rv)) begin
            @(negedge clk);
            w++;
        end
        // A hung answer counts against the run even if the sizes agree.
        if (w >= 3000) bad_count++;
        repeat (3) @(negedge clk);
        chk("rf_len", rs.size(), ex.size());
        chk("rf_last", rf_lst, ex.size() - 1);
        foreach (ex[i]) chk("rf_byte", rs[i], ex[i]);
        if (g) chk("host_len", hq.size(), hx.size());
        if (g) chk("host_last", hs_lst, hx.size() - 1);
        if (g) foreach (hx[i]) chk("host_byte", hq[i], hx[i]);
    endtask : run
    // Block protocol request with its expected answers.
    task blk(input logic [7:0] c, k, m, input bit dif, hok, ok);
        fr.delete();
        ex.delete();
        rf_ap = 1'b0;
        fr.push_back(c);
        for (int i = 0; i < 8; i++) fr.push_back(8'h10 + i[7:0]);
        fr.push_back(k);
        for (int i = 0; i < k; i++) fr.push_back(8'h09);
        for (int i = 0; i < k; i++) fr.insert(11 + 2 * i, (dif && i == 1));
        fr.push_back(m);
        for (int i = 0; i < 2 * m; i++) fr.push_back(i[0] ? 8'h01 : 8'h80);
        for (int i = 0; i < 16 * m && c == 8'h08; i++) fr.push_back(~i[7:0]);
        ex = {c + 8'h01, fr[1:8], ok && hok ? 8'h00 : 8'hFF};
        ex.push_back(ok && hok ? 8'h00 : 8'h01);
        if (c == 8'h06 && ok && hok) ex.push_back(m);
        for (int i = 0; i < 16 * m && c == 8'h06 && ok && hok; i++)
            ex.push_back(8'h40 + i[7:0]);
        hx = {QS, 8'h00, 8'h10, m * 8'h10};
        for (int i = 0; i < 16 * m && c == 8'h08; i++) hx.push_back(~i[7:0]);
        hx.push_back(AS);
        run(ok, !hok, c == 8'h06, 1'b0);
    endtask : blk
    // APDU request with its expected answers.
    task apdu(input logic [7:0] cla, ins, n, input bit hok, ok, s);
        rf_ap = 1'b1;
        fr = {cla, ins, 8'h12, 8'h34, n};
        for (int i = 0; i < n && ins == 8'hD6; i++) fr.push_back(~i[7:0]);
        hx = {QS, fr[2:$]};
        if (ins == 8'hB0) hx = hx[0:3];
        hx.push_back(AS);
        ex.delete();
        for (int i = 0; i < n && ins == 8'hB0 && ok && hok; i++)
            ex.push_back(8'h40 + i[7:0]);
        ex = {ex, ok && hok ? 8'h90 : 8'h6A, ok && hok ? 8'h00 : 8'h80};
        run(ok, !hok, ins == 8'hB0, s);
    endtask : apdu
    // Clock source.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Watchdog well beyond the expected run of some 3000 cycles.
    initial begin
        #500000;
        bad_count++;
        final_report();
    end
    // Reset, then every scenario in turn.
    initial begin
        {rst_n, rf_v, rf_l, rf_ap, go, err, rd, slow} = '0;
        rf_d = 8'h00;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        blk(8'h06, 8'h01, 8'h01, 1'b0, 1'b1, 1'b1);
        blk(8'h06, 8'h01, 8'h01, 1'b0, 1'b0, 1'b1);
        apdu(8'h00, 8'hB0, 8'hFB, 1'b1, 1'b1, 1'b1);
        apdu(8'h00, 8'hB0, 8'h10, 1'b0, 1'b1, 1'b0);
        blk(8'h08, 8'h08, 8'h0C, 1'b0, 1'b1, 1'b1);
        blk(8'h08, 8'h0B, 8'h0B, 1'b0, 1'b1, 1'b1);
        blk(8'h08, 8'h00, 8'h01, 1'b0, 1'b1, 1'b0);
        blk(8'h08, 8'h0C, 8'h01, 1'b0, 1'b1, 1'b0);
        blk(8'h08, 8'h09, 8'h0C, 1'b0, 1'b1, 1'b0);
        blk(8'h08, 8'h01, 8'h0D, 1'b0, 1'b1, 1'b0);
        blk(8'h08, 8'h03, 8'h01, 1'b1, 1'b1, 1'b0);
        blk(8'h08, 8'h02, 8'h01, 1'b0, 1'b0, 1'b1);
        apdu(8'h00, 8'hD6, 8'hF8, 1'b1, 1'b1, 1'b0);
        apdu(8'h01, 8'hD6, 8'h10, 1'b1, 1'b0, 1'b0);
        apdu(8'h00, 8'hD6, 8'h01, 1'b0, 1'b1, 1'b1);
        final_report();
    end
endmodule : tb_tunnel_mode_frame_handler
`default_nettype wire
